// [hw/motion_cfg.svh]
// Offsets, field positions, reset values and limits of the direction and pitch block.
// Assumes inclusion by bare name from every file that needs these constants.
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define OFS_CTRL        8'h00
`define OFS_PITCH       8'h04
`define OFS_PITCH_ACT   8'h08
`define OFS_STATUS      8'h0C
`define OFS_IRQ_STAT    8'h10
`define OFS_IRQ_MASK    8'h14
`define OFS_POSITION    8'h18

// ****************************************
// Field positions
// ****************************************
`define CTRL_DIR_SEL    0
`define CTRL_RESTART    8
`define ST_ALARM        0
`define ST_DIR_SEL      1
`define ST_LINEAR       2
`define ST_CONVERTER    3
`define ST_FWD_OT       4
`define ST_REV_OT       5
`define ST_PITCH_CHG    6
`define IRQ_ALARM       0
`define IRQ_FWD_BLOCK   1
`define IRQ_REV_BLOCK   2
`define IRQ_W           3

// ****************************************
// Reset values and limits
// ****************************************
`define PITCH_W         23
`define PITCH_DEFAULT   23'h000000
`define PITCH_MAX       23'h640000
`define DIR_SEL_DEFAULT 1'b0
`define IRQ_MASK_RESET  3'h0

`endif

// [hw/motion_pkg.sv]
// Types and the shared direction helper of the direction and pitch block.
// Assumes nothing of its surroundings.
package motion_pkg;

   // ****************************************
   // Start-up sequencing
   // ****************************************
   typedef enum logic [1:0] {
      ST_BOOT = 2'b01,
      ST_RUN  = 2'b10
   } boot_state_t;

   // Turns a reference direction (1 = reverse) into a physical one (1 = CW / count-down).
   // The same mapping also turns a physical encoder direction back into a reference one.
   function automatic logic apply_dir(input logic dir, input logic sel);
      apply_dir = dir ^ sel;
   endfunction : apply_dir

endpackage : motion_pkg

// [hw/quad_decode.sv]
// Quadrature decoder for the motor encoder: one step pulse per valid edge.
// Assumes enc_a and enc_b are already synchronous to clk.
module quad_decode (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Encoder lines
   input  wire logic enc_a,
   input  wire logic enc_b,
   // Decoded motion
   output logic      step,
   output logic      count_down
);

   logic [1:0] prev_q, prev_d;
   logic       step_q, step_d;
   logic       down_q, down_d;

   // A single-line change is a step; a double change is a glitch and is dropped.
   always_comb begin
      prev_d = {enc_a, enc_b};
      step_d = (enc_a ^ prev_q[1]) ^ (enc_b ^ prev_q[0]);
      down_d = down_q;
      if (step_d) begin
         down_d = ~(enc_a ^ prev_q[0]); // A leading B counts up.
      end
   end

   // Registered so downstream logic sees a clean one-cycle step.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 2'h0;
         step_q <= 1'b0;
         down_q <= 1'b0;
      end else if (ce) begin
         prev_q <= prev_d;
         step_q <= step_d;
         down_q <= down_d;
      end
   end

   assign step       = step_q;
   assign count_down = down_q;

endmodule : quad_decode

// [hw/quad_emit.sv]
// Quadrature pulse generator for the divided pulse outputs.
// Assumes one step request per cycle at most, direction given in reference terms.
module quad_emit (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // Step request
   input  wire logic step,
   input  wire logic reverse,
   // Pulse pair
   output logic      out_a,
   output logic      out_b
);

   logic [1:0] idx_q, idx_d;
   logic       a_q, a_d;
   logic       b_q, b_d;

   // Forward walks 00,01,11,10 in (A,B), so B leads A; reverse walks back, so A leads.
   always_comb begin
      idx_d = idx_q;
      if (step) begin
         idx_d = reverse ? idx_q - 2'h1 : idx_q + 2'h1;
      end
      a_d = idx_d[1];
      b_d = idx_d[1] ^ idx_d[0];
   end

   // Outputs are flops so the pair never glitches between states.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= 2'h0;
         a_q   <= 1'b0;
         b_q   <= 1'b0;
      end else if (ce) begin
         idx_q <= idx_d;
         a_q   <= a_d;
         b_q   <= b_d;
      end
   end

   assign out_a = a_q;
   assign out_b = b_q;

endmodule : quad_emit

// [hw/motion_direction_and_scale_pitch.sv]
// Direction selection, overtravel gating, divided pulse output and scale pitch alarm.
// Assumes a classic Wishbone master, synchronous pins and straps stable around a restart.
`include "motion_cfg.svh"

// Behaviour
// - Direction-select 0 makes forward CCW from load end; 1 makes forward CW.
// - Changing direction-select reverses motor motion without touching reference sign.
// - Divided pulse output polarity follows the reference, never direction-select.
// - Forward reference gives B leading A; reverse gives A leading B.
// - Linear motor: forward moves count-up when select is 0, count-down when 1.
// - Pitch alarm raised at start-up, for a linear motor with serial converter only, while scale pitch has not been set to a non-default value since power-on.
// - Pitch alarm clears only after pitch change followed by a restart.
// - Without serial converter the automatic pitch is used, programmed pitch ignored.
module motion_direction_and_scale_pitch (
   // Clock, reset and freeze
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Motor type straps and automatic pitch
   input  wire logic        linear_motor_in,
   input  wire logic        converter_in,
   input  wire logic [22:0] auto_pitch_in,
   // Motion reference
   input  wire logic        ref_step,
   input  wire logic        ref_reverse,
   input  wire logic        fwd_overtravel_in,
   input  wire logic        rev_overtravel_in,
   // Motor drive and encoder feedback
   output logic             motor_step,
   output logic             motor_dir_cw,
   input  wire logic        enc_a,
   input  wire logic        enc_b,
   // Divided pulse outputs
   output logic             pulse_out_a,
   output logic             pulse_out_b,
   // Status
   output logic             pitch_alarm,
   output logic             irq
);

   // ****************************************
   // Declarations
   // ****************************************
   logic                     wr_stb, rd_stb;
   motion_pkg::boot_state_t  boot_q, boot_d;
   logic                     dir_sel_q, dir_sel_d;
   logic [`PITCH_W-1:0]      pitch_q, pitch_d;
   logic [`PITCH_W-1:0]      pitch_act_q, pitch_act_d;
   logic                     pitch_chg_q, pitch_chg_d;
   logic                     linear_q, linear_d;
   logic                     conv_q, conv_d;
   logic                     alarm_q, alarm_d;
   logic [`IRQ_W-1:0]        irq_stat_q, irq_stat_d;
   logic [`IRQ_W-1:0]        irq_mask_q, irq_mask_d;
   logic                     irq_q, irq_d;
   logic [31:0]              rdata_q, rdata_d;
   logic                     ack_q, ack_d;
   logic                     mstep_q, mstep_d;
   logic                     mdir_q, mdir_d;
   logic                     fwd_block, rev_block;
   logic [31:0]              pos_q, pos_d;
   logic                     enc_step, enc_down;
   logic                     emit_reverse;
   logic                     soft_restart;
   logic [31:0]              wmask;
   logic [31:0]              wdata;

   // ****************************************
   // Bus decode
   // ****************************************

   // One access per cycle of the master; the ack flop keeps a held request from repeating.
   assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
   assign rd_stb = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_q;

   // Byte enables become a bit mask merged with the old value of the target.
   assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign wdata = wb_dat_i & wmask;

   assign soft_restart = wr_stb & (wb_adr_i == `OFS_CTRL) & wmask[`CTRL_RESTART]
                         & wb_dat_i[`CTRL_RESTART];

   // ****************************************
   // Start-up and setting registers
   // ****************************************

   // Straps and the pitch are caught one cycle after reset release or a soft restart,
   // so nothing under the asynchronous reset ever samples a pin.
   always_comb begin
      boot_d      = boot_q;
      dir_sel_d   = dir_sel_q;
      pitch_d     = pitch_q;
      pitch_chg_d = pitch_chg_q;
      pitch_act_d = pitch_act_q;
      linear_d    = linear_q;
      conv_d      = conv_q;
      alarm_d     = alarm_q;
      irq_mask_d  = irq_mask_q;
      if (wr_stb) begin
         unique case (wb_adr_i)
            `OFS_CTRL: begin
               if (wmask[`CTRL_DIR_SEL]) begin
                  dir_sel_d = wb_dat_i[`CTRL_DIR_SEL];
               end
            end
            `OFS_PITCH: begin
               // Out-of-range values are refused so the stored setting stays legal.
               if ((((pitch_q & ~wmask[`PITCH_W-1:0]) | wdata[`PITCH_W-1:0]) <= `PITCH_MAX)
                   && (wdata[31:`PITCH_W] == 9'h000)) begin
                  pitch_d = (pitch_q & ~wmask[`PITCH_W-1:0]) | wdata[`PITCH_W-1:0];
                  if (pitch_d != `PITCH_DEFAULT) begin
                     pitch_chg_d = 1'b1;
                  end
               end
            end
            `OFS_IRQ_MASK: begin
               irq_mask_d = (irq_mask_q & ~wmask[`IRQ_W-1:0]) | wdata[`IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
      unique case (boot_q)
         motion_pkg::ST_BOOT: begin
            linear_d = linear_motor_in;
            conv_d   = converter_in;
            // Pitch only takes effect here; without a converter the scale tells its own.
            pitch_act_d = converter_in ? pitch_q : auto_pitch_in;
            alarm_d     = linear_motor_in & converter_in & ~pitch_chg_q;
            boot_d      = motion_pkg::ST_RUN;
         end
         motion_pkg::ST_RUN: begin
            if (soft_restart) begin
               boot_d = motion_pkg::ST_BOOT;
            end
         end
         default: begin
            boot_d = motion_pkg::ST_BOOT;
         end
      endcase
   end

   // Settings survive a soft restart; only the power-on reset returns them to defaults.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_q      <= motion_pkg::ST_BOOT;
         dir_sel_q   <= `DIR_SEL_DEFAULT;
         pitch_q     <= `PITCH_DEFAULT;
         pitch_chg_q <= 1'b0;
         pitch_act_q <= `PITCH_DEFAULT;
         linear_q    <= 1'b0;
         conv_q      <= 1'b0;
         alarm_q     <= 1'b0;
         irq_mask_q  <= `IRQ_MASK_RESET;
      end else if (ce) begin
         boot_q      <= boot_d;
         dir_sel_q   <= dir_sel_d;
         pitch_q     <= pitch_d;
         pitch_chg_q <= pitch_chg_d;
         pitch_act_q <= pitch_act_d;
         linear_q    <= linear_d;
         conv_q      <= conv_d;
         alarm_q     <= alarm_d;
         irq_mask_q  <= irq_mask_d;
      end
   end

   // ****************************************
   // Motion path
   // ****************************************

   // Overtravel is judged on the reference direction, so the selection cannot swap limits.
   assign fwd_block = ~ref_reverse & fwd_overtravel_in;
   assign rev_block = ref_reverse & rev_overtravel_in;

   // Physical direction is the reference direction turned by the selection.
   always_comb begin
      mstep_d = ref_step & ~fwd_block & ~rev_block & (boot_q == motion_pkg::ST_RUN);
      mdir_d  = mdir_q;
      if (ref_step) begin
         mdir_d = motion_pkg::apply_dir(ref_reverse, dir_sel_q);
      end
      pos_d = pos_q;
      if (enc_step) begin
         pos_d = enc_down ? pos_q - 32'h00000001 : pos_q + 32'h00000001;
      end
   end

   // Encoder counts stay physical; only the pulse outputs are mapped back.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mstep_q <= 1'b0;
         mdir_q  <= 1'b0;
         pos_q   <= 32'h00000000;
      end else if (ce) begin
         mstep_q <= mstep_d;
         mdir_q  <= mdir_d;
         pos_q   <= pos_d;
      end
   end

   quad_decode u_decode (
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .enc_a      (enc_a),
      .enc_b      (enc_b),
      .step       (enc_step),
      .count_down (enc_down)
   );

   // Turning the physical step back into reference terms keeps the pulse polarity fixed.
   assign emit_reverse = motion_pkg::apply_dir(enc_down, dir_sel_q);

   quad_emit u_emit (
      .clk     (clk),
      .rst_n   (rst_n),
      .ce      (ce),
      .step    (enc_step),
      .reverse (emit_reverse),
      .out_a   (pulse_out_a),
      .out_b   (pulse_out_b)
   );

   // ****************************************
   // Interrupts and bus answer
   // ****************************************

   // Events set sticky bits; a read clears, but an event in the same cycle wins.
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (rd_stb && (wb_adr_i == `OFS_IRQ_STAT)) begin
         irq_stat_d = {`IRQ_W{1'b0}};
      end
      if ((boot_q == motion_pkg::ST_BOOT) && alarm_d) begin
         irq_stat_d[`IRQ_ALARM] = 1'b1;
      end
      if (ref_step && fwd_block) begin
         irq_stat_d[`IRQ_FWD_BLOCK] = 1'b1;
      end
      if (ref_step && rev_block) begin
         irq_stat_d[`IRQ_REV_BLOCK] = 1'b1;
      end
      irq_d = |(irq_stat_d & irq_mask_d);
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      rdata_d = 32'h00000000;
      if (rd_stb) begin
         unique case (wb_adr_i)
            `OFS_CTRL:      rdata_d[`CTRL_DIR_SEL] = dir_sel_q;
            `OFS_PITCH:     rdata_d[`PITCH_W-1:0] = pitch_q;
            `OFS_PITCH_ACT: rdata_d[`PITCH_W-1:0] = pitch_act_q;
            `OFS_STATUS: begin
               rdata_d[`ST_ALARM]     = alarm_q;
               rdata_d[`ST_DIR_SEL]   = dir_sel_q;
               rdata_d[`ST_LINEAR]    = linear_q;
               rdata_d[`ST_CONVERTER] = conv_q;
               rdata_d[`ST_FWD_OT]    = fwd_overtravel_in;
               rdata_d[`ST_REV_OT]    = rev_overtravel_in;
               rdata_d[`ST_PITCH_CHG] = pitch_chg_q;
            end
            `OFS_IRQ_STAT:  rdata_d[`IRQ_W-1:0] = irq_stat_q;
            `OFS_IRQ_MASK:  rdata_d[`IRQ_W-1:0] = irq_mask_q;
            `OFS_POSITION:  rdata_d = pos_q;
            default:        rdata_d = 32'h00000000; // Unmapped reads answer zero.
         endcase
      end
   end

   // Every access is acked one cycle after it is presented, mapped or not.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_q <= {`IRQ_W{1'b0}};
         irq_q      <= 1'b0;
         ack_q      <= 1'b0;
         rdata_q    <= 32'h00000000;
      end else if (ce) begin
         irq_stat_q <= irq_stat_d;
         irq_q      <= irq_d;
         ack_q      <= ack_d;
         rdata_q    <= rdata_d;
      end
   end

   assign wb_dat_o     = rdata_q;
   assign wb_ack_o     = ack_q;
   assign motor_step   = mstep_q;
   assign motor_dir_cw = mdir_q;
   assign pitch_alarm  = alarm_q;
   assign irq          = irq_q;

endmodule : motion_direction_and_scale_pitch

// [testbench/motion_sva.sv]
// Port checks for the direction and pitch block.
// Assumes it is bound to the top module; one clock domain.
module motion_sva (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        ce,
   // Bus
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Motion
   input wire logic        ref_step,
   input wire logic        ref_reverse,
   input wire logic        fwd_overtravel_in,
   input wire logic        rev_overtravel_in,
   input wire logic        motor_step,
   input wire logic        motor_dir_cw,
   input wire logic        pulse_out_a,
   input wire logic        pulse_out_b
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // Properties
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // A taken request is answered on the next edge, with a single pulse.
   AST_ACK_NEXT: assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   // Overtravel blocks only its own reference direction.
   AST_FWD_BLOCK: assert property (ref_step && !ref_reverse && fwd_overtravel_in |=> !motor_step)
      else $error("forward step passed overtravel");
   AST_REV_BLOCK: assert property (ref_step && ref_reverse && rev_overtravel_in |=> !motor_step)
      else $error("reverse step passed overtravel");
   AST_STEP_CAUSE: assert property (motor_step |-> $past(ref_step))
      else $error("motor step without reference");
   AST_DIR_HOLD: assert property (!ref_step |=> $stable(motor_dir_cw))
      else $error("direction moved without reference");
   // A quadrature pair never changes both lines at once.
   AST_PULSE_GRAY: assert property (!($changed(pulse_out_a) && $changed(pulse_out_b)))
      else $error("both pulse lines changed together");
endmodule : motion_sva

bind motion_direction_and_scale_pitch motion_sva motion_sva_inst (
   .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .ref_step(ref_step), .ref_reverse(ref_reverse),
   .fwd_overtravel_in(fwd_overtravel_in), .rev_overtravel_in(rev_overtravel_in),
   .motor_step(motor_step), .motor_dir_cw(motor_dir_cw), .pulse_out_a(pulse_out_a),
   .pulse_out_b(pulse_out_b)
);

// [testbench/motor_model.sv]
// Behavioural motor whose encoder moves one phase per drive step.
// Assumes the encoder is powered and zeroed with the drive's reset.
module motor_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Drive
   input  wire logic motor_step,
   input  wire logic motor_dir_cw,
   // Encoder
   output logic      enc_a,
   output logic      enc_b
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_q;
   logic [1:0] phase_d;

   // CCW counts up, CW counts down; the shaft never skips a phase.
   always_comb begin
      phase_d = phase_q;
      if (motor_step) begin
         phase_d = motor_dir_cw ? phase_q - 2'h1 : phase_q + 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_d;
      end
   end

   // Gray order 00,10,11,01 puts A ahead of B when counting up.
   assign enc_a = phase_q[0] ^ phase_q[1];
   assign enc_b = phase_q[1];
endmodule : motor_model

// [testbench/motion_direction_and_scale_pitch_tb.sv]
// Self-checking bench for the direction and pitch block with a motor model.
// Assumes the design, motor_model and motion_cfg.svh are compiled alongside.
`include "motion_cfg.svh"
module motion_direction_and_scale_pitch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        linear_motor_in = 1'b0, converter_in = 1'b0;
   logic [22:0] auto_pitch_in = 23'h0007D0;
   logic        ref_step = 1'b0, ref_reverse = 1'b0;
   logic        fwd_overtravel_in = 1'b0, rev_overtravel_in = 1'b0;
   logic        motor_step, motor_dir_cw, enc_a, enc_b;
   logic        pulse_out_a, pulse_out_b, pitch_alarm, irq;
   int          n_errors = 0, checked = 0;

   always #10 clk = ~clk;

   motion_direction_and_scale_pitch motion_direction_and_scale_pitch_inst (
      .clk(clk), .rst_n(rst_n), .ce(ce), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .linear_motor_in(linear_motor_in),
      .converter_in(converter_in), .auto_pitch_in(auto_pitch_in), .ref_step(ref_step),
      .ref_reverse(ref_reverse), .fwd_overtravel_in(fwd_overtravel_in),
      .rev_overtravel_in(rev_overtravel_in), .motor_step(motor_step),
      .motor_dir_cw(motor_dir_cw), .enc_a(enc_a), .enc_b(enc_b), .pulse_out_a(pulse_out_a),
      .pulse_out_b(pulse_out_b), .pitch_alarm(pitch_alarm), .irq(irq));

   motor_model motor_model_inst (.clk(clk), .rst_n(rst_n), .motor_step(motor_step),
      .motor_dir_cw(motor_dir_cw), .enc_a(enc_a), .enc_b(enc_b));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // The request is held until ack is sampled high, so no cycle count is assumed.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= be;
      wb_dat_i <= d;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) begin
         @(posedge clk);
      end
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask : wb

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, 4'hF, q);
      chk($sformatf("reg %h", a), exp, q);
   endtask : rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      logic [31:0] q;
      wb(1'b1, a, d, be, q);
   endtask : wr

   task automatic step(input logic rev, input logic exp_step, input logic exp_cw);
      @(posedge clk);
      ref_step    <= 1'b1;
      ref_reverse <= rev;
      @(posedge clk);
      ref_step <= 1'b0;
      #1;
      chk("motor_step", 32'(exp_step), 32'(motor_step));
      chk("motor_dir_cw", 32'(exp_cw), 32'(motor_dir_cw));
   endtask : step

   task automatic wait_chk(input string what, input logic exp, ref logic sig);
      repeat (6) @(posedge clk);
      #1;
      chk(what, 32'(exp), 32'(sig));
   endtask : wait_chk

   task automatic power_on(input logic lin, input logic conv);
      rst_n           <= 1'b0;
      linear_motor_in <= lin;
      converter_in    <= conv;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : power_on

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_overtravel();
      wr(`OFS_IRQ_MASK, 32'h2);
      fwd_overtravel_in <= 1'b1;
      step(1'b0, 1'b0, 1'b0);
      wait_chk("irq set", 1'b1, irq);
      rd(`OFS_IRQ_STAT, 32'h2);
      rd(`OFS_IRQ_STAT, 32'h0);
      wait_chk("irq clear", 1'b0, irq);
      step(1'b1, 1'b1, 1'b1);
      @(posedge clk);
      rev_overtravel_in <= 1'b1;
      rd(`OFS_STATUS, 32'h30);
      step(1'b1, 1'b0, 1'b1);
      rd(`OFS_IRQ_STAT, 32'h4);
      wait_chk("irq masked", 1'b0, irq);
      @(posedge clk);
      fwd_overtravel_in <= 1'b0;
      rev_overtravel_in <= 1'b0;
   endtask : t_overtravel

   // A low enable must swallow a reference step and keep the last direction.
   task automatic t_freeze();
      @(posedge clk);
      ce <= 1'b0;
      step(1'b0, 1'b0, 1'b1);
      @(posedge clk);
      ce <= 1'b1;
   endtask : t_freeze

   // Without a converter the scale's own pitch wins over the programmed one.
   task automatic t_auto();
      wr(`OFS_PITCH, 32'h1234);
      wr(`OFS_CTRL, 32'h100);
      rd(`OFS_PITCH_ACT, 32'h7D0);
      rd(`OFS_STATUS, 32'h44);
      wait_chk("alarm", 1'b0, pitch_alarm);
   endtask : t_auto

   // Pulse polarity follows the reference alone, whatever the selection.
   task automatic t_direction();
      for (int s = 0; s < 2; s++) begin
         wr(`OFS_CTRL, 32'(s));
         step(1'b0, 1'b1, s[0]);
         wait_chk("pulse_out_b", 1'b1, pulse_out_b);
         chk("pulse_out_a", 32'h0, 32'(pulse_out_a));
         rd(`OFS_POSITION, s[0] ? 32'hFFFFFFFF : 32'h00000001);
         step(1'b1, 1'b1, !s[0]);
         wait_chk("pulse_out_b", 1'b0, pulse_out_b);
         chk("pulse_out_a", 32'h0, 32'(pulse_out_a));
         rd(`OFS_POSITION, 32'h0);
      end
   endtask : t_direction

   task automatic t_pitch();
      rd(`OFS_STATUS, 32'hD);
      wait_chk("alarm", 1'b1, pitch_alarm);
      wait_chk("irq masked", 1'b0, irq);
      wr(`OFS_IRQ_MASK, 32'h1);
      wait_chk("irq", 1'b1, irq);
      rd(`OFS_IRQ_STAT, 32'h1);
      wait_chk("irq clear", 1'b0, irq);
      wr(`OFS_PITCH, 32'(`PITCH_MAX) + 32'h1);
      rd(`OFS_PITCH, 32'h0);
      wr(`OFS_PITCH, 32'(`PITCH_MAX));
      rd(`OFS_PITCH, 32'h640000);
      rd(`OFS_PITCH_ACT, 32'h0);
      wait_chk("alarm held", 1'b1, pitch_alarm);
      wr(`OFS_CTRL, 32'h100);
      wait_chk("alarm", 1'b0, pitch_alarm);
      rd(`OFS_PITCH_ACT, 32'h640000);
      rd(`OFS_STATUS, 32'h4C);
      rd(`OFS_CTRL, 32'h0);
      rd(8'h1C, 32'h0);
      wr(`OFS_PITCH, 32'h00120034, 4'h4);
      rd(`OFS_PITCH, 32'h00120000);
      wr(`OFS_PITCH, 32'h00800000);
      rd(`OFS_PITCH, 32'h00120000);
   endtask : t_pitch

   task automatic test_done();
      $display("Comparisons %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : test_done

   initial begin
      power_on(1'b0, 1'b0);
      t_overtravel();
      t_freeze();
      power_on(1'b1, 1'b0);
      t_auto();
      t_direction();
      power_on(1'b1, 1'b1);
      t_pitch();
      test_done();
   end

   // The whole run needs well under 2000 cycles.
   initial begin
      #200us;
      n_errors++;
      test_done();
   end
endmodule : motion_direction_and_scale_pitch_tb
